//--- emb_bus.sv
// expanded memory bus engine with ahb-lite register slave
// Function
// - fetch code over the bus when program space is mapped outside internal ram
// - external fetch drives full 16-bit address, high byte high port, low byte low port
// - strong pull-ups on port pins outputting address ones
// - address ports leave general use while code runs externally
// - low address valid at ale falling edge; external latch captures it there
// - ale pulses twice per machine cycle during program access
// - any external fetch or data access sets low port latch to all ones
// - ones on low port during bus cycles are actively driven
// - program read strobe pulses only for external fetches
// - program read strobe twice per cycle, once in first data-move cycle, never in the second
// - one external fetch spans six oscillator periods
// - data move to location outside internal ram uses the bus
// - pointer data access drives 16-bit address, high latch unchanged
// - high port shows its latch again after a pointer access
// - first ale suppressed in second cycle of a data move
// - register-indirect access drives 8-bit address; high port shows latch
// - read strobe in second cycle; read takes twelve periods, no program strobe
// - write data on low port before write strobe, held until release
// - machine cycle is twelve periods: six states of two phases
// - two code bytes read per cycle at first and fourth state
// - data access spans fourth state of cycle one to third of two
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`default_nettype none
module emb_bus (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic external_access_pin_n,
    input wire emb_pkg::emb_byte_t low_addr_data_port_in,
    output emb_pkg::emb_byte_t low_addr_data_port_out,
    output emb_pkg::emb_byte_t low_addr_data_port_oe,
    output emb_pkg::emb_byte_t low_addr_data_port_pu,
    output emb_pkg::emb_byte_t high_addr_port_out,
    output emb_pkg::emb_byte_t high_addr_port_oe,
    output emb_pkg::emb_byte_t high_addr_port_pu,
    output logic ale,
    output logic program_read_strobe_n,
    output logic read_strobe_pin_n,
    output logic write_strobe_pin_n,
    output logic ports_claimed
);
    import emb_pkg::*;

    typedef struct packed {
        emb_mc_t st;
        logic run;
        logic rng;
        logic lock;
        logic [7:0] part;
        logic [15:0] pc;
        logic [15:0] data_pointer_reg;
        logic [7:0] p0l;
        logic [7:0] p2l;
        logic pend;
        logic wr;
        logic use_ptr;
        logic dext;
        logic [7:0] reg_a;
        logic [7:0] wd;
        logic [7:0] code;
        logic [7:0] rdat;
        logic [1:0] cap;
        logic cap_rd;
        logic xa1;
        logic xa2;
        logic xa3;
        logic xa_n;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic fext;
        logic hext;
        logic act;
        logic rdy;
        logic wpend;
        logic [7:0] waddr;
        logic [31:0] hrd;
        logic ale;
        logic prd_n;
        logic rd_n;
        logic wr_n;
        logic claim;
        logic [7:0] p0o;
        logic [7:0] p0oe;
        logic [7:0] p0pu;
        logic [7:0] p2o;
        logic [7:0] p2oe;
        logic [7:0] p2pu;
    } emb_core_t;

    emb_core_t s_ff;
    emb_core_t nxt;
    emb_tick_if tk ();
    logic fext_now;
    logic fetch_ext;
    logic [15:0] daddr;

    emb_timing u_timing (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .tk(tk)
    );

    // partition or range boundary; code may be forced out by the access pin
    function automatic logic is_ext(input logic [15:0] a, input logic prog,
                                    input emb_core_t s);
        logic [15:0] bound;
        bound = s.rng ? RANGE_BOUND : {s.part, 8'h00};
        is_ext = (prog && !s.xa_n && !s.lock) || (a >= bound);
    endfunction

    assign fext_now = is_ext(s_ff.pc, 1'b1, s_ff);
    // mapping looked at once per half, so a pin change never cuts a strobe short
    assign fetch_ext = (tk.sub == 4'h0) ? fext_now : s_ff.hext;
    assign daddr = s_ff.use_ptr ? s_ff.data_pointer_reg : {s_ff.p2l, s_ff.reg_a};

    always_comb begin
        nxt = s_ff;
        // pin synchronisers: a change counts once stages two and three agree
        nxt.xa1 = external_access_pin_n;
        nxt.xa2 = s_ff.xa1;
        nxt.xa3 = s_ff.xa2;
        if (s_ff.xa2 == s_ff.xa3) begin
            nxt.xa_n = s_ff.xa3;
        end
        nxt.d1 = low_addr_data_port_in;
        nxt.d2 = s_ff.d1;
        nxt.d3 = s_ff.d2;
        nxt.fext = fext_now;
        nxt.hext = fetch_ext;
        // bus slave: zero wait, always okay
        nxt.rdy = 1'b1;
        nxt.wpend = 1'b0;
        if (s_ff.wpend) begin
            case (s_ff.waddr)
                OFS_CFG: begin
                    nxt.part = hwdata[CFG_PART_LSB +: 8];
                    nxt.rng = hwdata[CFG_RANGE_BIT];
                    nxt.lock = hwdata[CFG_LOCK_BIT];
                    nxt.run = hwdata[CFG_RUN_BIT];
                end
                OFS_PC: nxt.pc = hwdata[15:0];
                OFS_DATA_POINTER_REG: nxt.data_pointer_reg = hwdata[15:0];
                OFS_PORT: begin
                    nxt.p0l = hwdata[PORT_LOW_LSB +: 8];
                    nxt.p2l = hwdata[PORT_HIGH_LSB +: 8];
                end
                OFS_XCMD: begin
                    // a command while one is queued or running is dropped
                    if (!s_ff.pend && s_ff.st == EMB_NORM) begin
                        nxt.pend = 1'b1;
                        nxt.wd = hwdata[XCMD_WD_LSB +: 8];
                        nxt.reg_a = hwdata[XCMD_REG_LSB +: 8];
                        nxt.wr = hwdata[XCMD_WR_BIT];
                        nxt.use_ptr = hwdata[XCMD_PTR_BIT];
                    end
                end
                default: ;
            endcase
        end
        if (hready && hsel && htrans[1]) begin
            if (hwrite) begin
                nxt.wpend = 1'b1;
                nxt.waddr = haddr[7:0];
            end else begin
                nxt.hrd = 32'h0;
                case (haddr[7:0])
                    OFS_CFG: nxt.hrd = {21'h0, s_ff.run, s_ff.lock, s_ff.rng, s_ff.part};
                    OFS_PC: nxt.hrd = {16'h0, s_ff.pc};
                    OFS_DATA_POINTER_REG: nxt.hrd = {16'h0, s_ff.data_pointer_reg};
                    OFS_PORT: nxt.hrd = {16'h0, s_ff.p2l, s_ff.p0l};
                    OFS_XCMD: nxt.hrd = {14'h0, s_ff.use_ptr, s_ff.wr, s_ff.reg_a, s_ff.wd};
                    OFS_STAT: nxt.hrd = {14'h0, s_ff.fext,
                                         s_ff.pend || s_ff.st != EMB_NORM,
                                         s_ff.rdat, s_ff.code};
                    default: nxt.hrd = 32'h0;
                endcase
            end
        end
        // pins default to the port latches, quasi-bidirectional
        nxt.ale = 1'b0;
        nxt.prd_n = 1'b1;
        nxt.rd_n = 1'b1;
        nxt.wr_n = 1'b1;
        nxt.claim = 1'b0;
        nxt.p0o = s_ff.p0l;
        nxt.p0oe = ~s_ff.p0l;
        nxt.p0pu = 8'h00;
        nxt.p2o = s_ff.p2l;
        nxt.p2oe = ~s_ff.p2l;
        nxt.p2pu = 8'h00;
        // late capture covers the three-stage input synchroniser
        if (s_ff.cap != 2'h0) begin
            nxt.cap = s_ff.cap - 2'h1;
            if (s_ff.cap == 2'h1 && s_ff.d2 == s_ff.d3) begin
                if (s_ff.cap_rd) begin
                    nxt.rdat = s_ff.d3;
                end else begin
                    nxt.code = s_ff.d3;
                end
            end
        end
        // run only takes hold at a machine cycle boundary
        if (tk.last) begin
            nxt.act = s_ff.run;
        end
        if (s_ff.act) begin
            // ale in every half except the first half of the second move cycle
            if (tk.sub < SUB_ALE_OFF && !(s_ff.st == EMB_MX2 && !tk.half)) begin
                nxt.ale = 1'b1;
            end
            if (s_ff.st == EMB_NORM || (s_ff.st == EMB_MX1 && !tk.half) ||
                (s_ff.st == EMB_MX2 && tk.half)) begin
                if (fetch_ext) begin
                    nxt.claim = 1'b1;
                    nxt.p0l = 8'hff;
                    nxt.p2o = s_ff.pc[15:8];
                    nxt.p2oe = 8'hff;
                    nxt.p2pu = s_ff.pc[15:8];
                    if (tk.sub <= SUB_ALE_OFF) begin
                        nxt.p0o = s_ff.pc[7:0];
                        nxt.p0oe = 8'hff;
                        nxt.p0pu = s_ff.pc[7:0];
                    end else begin
                        nxt.p0oe = 8'h00;
                    end
                    // no program strobe in the second cycle of a data move
                    if (tk.sub >= SUB_STB_ON && s_ff.st != EMB_MX2) begin
                        nxt.prd_n = 1'b0;
                    end
                    if (tk.sub == SUB_REL && s_ff.st != EMB_MX2) begin
                        nxt.cap = CAP_DELAY;
                        nxt.cap_rd = 1'b0;
                    end
                end
                // one code byte per half, in first and fourth state
                if (tk.sub == SUB_REL) begin
                    nxt.pc = s_ff.pc + 16'h1;
                end
            end
            if (s_ff.dext && ((s_ff.st == EMB_MX1 && tk.half) ||
                (s_ff.st == EMB_MX2 && !tk.half))) begin
                nxt.claim = 1'b1;
                nxt.p0l = 8'hff;
                nxt.p2oe = 8'hff;
                // pointer high byte drives the pins, latch itself untouched
                nxt.p2o = s_ff.use_ptr ? s_ff.data_pointer_reg[15:8] : s_ff.p2l;
                nxt.p2pu = s_ff.use_ptr ? s_ff.data_pointer_reg[15:8] : 8'h00;
                if (s_ff.st == EMB_MX1 && tk.sub <= SUB_ALE_OFF) begin
                    nxt.p0o = daddr[7:0];
                    nxt.p0oe = 8'hff;
                    nxt.p0pu = daddr[7:0];
                end else if (s_ff.wr) begin
                    nxt.p0o = s_ff.wd;
                    nxt.p0oe = 8'hff;
                end else begin
                    nxt.p0oe = 8'h00;
                end
                if (s_ff.st == EMB_MX2 && tk.idx >= XSTB_ON && tk.idx < XSTB_OFF) begin
                    nxt.rd_n = s_ff.wr;
                    nxt.wr_n = !s_ff.wr;
                end
                if (s_ff.st == EMB_MX2 && tk.idx == XSTB_OFF && !s_ff.wr) begin
                    nxt.cap = CAP_DELAY;
                    nxt.cap_rd = 1'b1;
                end
            end
            if (tk.last) begin
                case (s_ff.st)
                    EMB_NORM: begin
                        if (s_ff.pend) begin
                            nxt.st = EMB_MX1;
                            nxt.pend = 1'b0;
                            nxt.dext = is_ext(daddr, 1'b0, s_ff);
                        end
                    end
                    EMB_MX1: nxt.st = EMB_MX2;
                    EMB_MX2: begin
                        nxt.st = EMB_NORM;
                        nxt.dext = 1'b0;
                    end
                    default: nxt.st = EMB_NORM;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.st <= EMB_NORM;
            s_ff.part <= RST_PART;
            s_ff.p0l <= RST_PORT_LATCH;
            s_ff.p2l <= RST_PORT_LATCH;
            s_ff.xa1 <= 1'b1;
            s_ff.xa2 <= 1'b1;
            s_ff.xa3 <= 1'b1;
            s_ff.xa_n <= 1'b1;
            s_ff.rdy <= 1'b1;
            s_ff.prd_n <= 1'b1;
            s_ff.rd_n <= 1'b1;
            s_ff.wr_n <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt;
        end
    end

    assign hreadyout = s_ff.rdy;
    assign hrdata = s_ff.hrd;
    assign hresp = 1'b0;
    assign low_addr_data_port_out = s_ff.p0o;
    assign low_addr_data_port_oe = s_ff.p0oe;
    assign low_addr_data_port_pu = s_ff.p0pu;
    assign high_addr_port_out = s_ff.p2o;
    assign high_addr_port_oe = s_ff.p2oe;
    assign high_addr_port_pu = s_ff.p2pu;
    assign ale = s_ff.ale;
    assign program_read_strobe_n = s_ff.prd_n;
    assign read_strobe_pin_n = s_ff.rd_n;
    assign write_strobe_pin_n = s_ff.wr_n;
    assign ports_claimed = s_ff.claim;

    // checks assume ce stays high
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_prd_ext;
        !s_ff.prd_n |-> $past(fetch_ext) && s_ff.claim;
    endproperty
    a_prd_ext: assert property (p_prd_ext) else $error("program strobe on internal fetch");
    property p_prd_move;
        s_ff.st == EMB_MX2 |=> s_ff.prd_n;
    endproperty
    a_prd_move: assert property (p_prd_move) else $error("program strobe in move cycle");
    property p_prd_len;
        $fell(s_ff.prd_n) |-> !s_ff.prd_n [*3] ##1 s_ff.prd_n;
    endproperty
    a_prd_len: assert property (p_prd_len) else $error("fetch strobe not three periods");
    property p_ale_addr;
        $fell(s_ff.ale) && s_ff.claim |-> (s_ff.p0oe == 8'hff) && (s_ff.p0pu == s_ff.p0o);
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("low address gone at ale fall");
    property p_ale_twice;
        ($rose(s_ff.ale) && s_ff.st == EMB_NORM && !tk.half) |-> ##6 $rose(s_ff.ale);
    endproperty
    a_ale_twice: assert property (p_ale_twice) else $error("ale not twice per cycle");
    property p_latch_ones;
        $fell(s_ff.prd_n) || $fell(s_ff.rd_n) |-> s_ff.p0l == 8'hff;
    endproperty
    a_latch_ones: assert property (p_latch_ones) else $error("low latch not all ones");
    property p_no_first_ale;
        (s_ff.st == EMB_MX2 && !tk.half) |=> !s_ff.ale;
    endproperty
    a_no_first_ale: assert property (p_no_first_ale) else $error("first ale not dropped");
    property p_rd_len;
        $fell(s_ff.rd_n) |-> (!s_ff.rd_n && s_ff.prd_n) [*4] ##1 s_ff.rd_n;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe shape wrong");
    property p_wr_data;
        !s_ff.wr_n |-> s_ff.p0oe == 8'hff && s_ff.p0o == s_ff.wd;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not held");
    property p_ind_high;
        ((!s_ff.rd_n || !s_ff.wr_n) && !s_ff.use_ptr) |-> high_addr_port_out == s_ff.p2l;
    endproperty
    a_ind_high: assert property (p_ind_high) else $error("high port left latch");
    c_fetch: cover property ($fell(s_ff.prd_n));
    c_read: cover property ($fell(s_ff.rd_n));
    c_write: cover property ($fell(s_ff.wr_n));
endmodule
`default_nettype wire

//--- emb_mem_model.sv
// behavioural address latch and external memory on the expanded bus
`default_nettype none
module emb_mem_model (
    input wire logic clock,
    input wire logic ale,
    input wire logic [7:0] low_pins,
    input wire logic [7:0] high_pins,
    input wire logic program_read_strobe_n,
    input wire logic read_strobe_pin_n,
    input wire logic write_strobe_pin_n,
    output logic [7:0] drive,
    output logic drive_oe,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] addr_lat = 8'h00;
    logic [7:0] last = 8'h00;
    // transparent latch closes on the falling strobe
    always @(negedge ale) addr_lat <= low_pins;
    assign drive_oe = !program_read_strobe_n || !read_strobe_pin_n;
    // released lines show the inverse of the last byte, so stale data never looks valid
    assign drive = drive_oe ? (addr_lat ^ high_pins ^ 8'h3c) : ~last;
    always @(posedge clock) begin
        if (drive_oe) begin
            last <= drive;
        end
        if (!write_strobe_pin_n) begin
            wr_addr <= {high_pins, addr_lat};
            wr_data <= low_pins;
        end
    end
endmodule
`default_nettype wire

//--- emb_pkg.sv
// constants and types for the expanded memory bus block
`default_nettype none
package emb_pkg;
    typedef logic [7:0] emb_byte_t;
    // register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_XCMD = 8'h08;
    localparam logic [7:0] OFS_DATA_POINTER_REG = 8'h0c;
    localparam logic [7:0] OFS_PORT = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // field positions
    localparam int CFG_PART_LSB = 0;
    localparam int CFG_RANGE_BIT = 8;
    localparam int CFG_LOCK_BIT = 9;
    localparam int CFG_RUN_BIT = 10;
    localparam int XCMD_WD_LSB = 0;
    localparam int XCMD_REG_LSB = 8;
    localparam int XCMD_WR_BIT = 16;
    localparam int XCMD_PTR_BIT = 17;
    localparam int PORT_LOW_LSB = 0;
    localparam int PORT_HIGH_LSB = 8;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_RDAT_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;
    localparam int STAT_FEXT_BIT = 17;
    // reset values
    localparam logic [7:0] RST_PORT_LATCH = 8'hff;
    localparam logic [7:0] RST_PART = 8'h80;
    localparam logic [15:0] RANGE_BOUND = 16'h8000;
    // timing in oscillator periods (one clock each)
    localparam logic [3:0] OSC_PER_MC = 4'hc;
    localparam logic [3:0] OSC_PER_HALF = 4'h6;
    localparam logic [3:0] SUB_ALE_OFF = 4'h2;
    localparam logic [3:0] SUB_STB_ON = 4'h3;
    localparam logic [3:0] SUB_REL = 4'h5;
    localparam logic [3:0] XSTB_ON = 4'h1;
    localparam logic [3:0] XSTB_OFF = 4'h5;
    localparam logic [1:0] CAP_DELAY = 2'h2;
    typedef enum logic [2:0] {
        EMB_NORM = 3'b001,
        EMB_MX1 = 3'b010,
        EMB_MX2 = 3'b100
    } emb_mc_t;
endpackage
`default_nettype wire

//--- emb_tick_if.sv
// machine cycle position carried from the timing module to the bus engine
`default_nettype none
interface emb_tick_if;
    logic [3:0] idx;
    logic half;
    logic [3:0] sub;
    logic last;
    modport src (output idx, half, sub, last);
    modport snk (input idx, half, sub, last);
endinterface
`default_nettype wire

//--- emb_timing.sv
// oscillator period counter forming six states of two phases per machine cycle
`default_nettype none
module emb_timing (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    emb_tick_if.src tk
);
    import emb_pkg::*;
    typedef struct packed {
        logic [3:0] idx;
    } emb_tm_t;
    emb_tm_t s_ff;
    emb_tm_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (s_ff.idx == OSC_PER_MC - 4'h1) begin
            nxt_s.idx = 4'h0;
        end else begin
            nxt_s.idx = s_ff.idx + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign tk.idx = s_ff.idx;
    assign tk.half = (s_ff.idx >= OSC_PER_HALF);
    assign tk.sub = (s_ff.idx >= OSC_PER_HALF) ? s_ff.idx - OSC_PER_HALF : s_ff.idx;
    assign tk.last = (s_ff.idx == OSC_PER_MC - 4'h1);

    property p_mc_wrap;
        @(posedge clock) disable iff (rst)
        (ce && s_ff.idx == 4'hb) |=> (s_ff.idx == 4'h0);
    endproperty
    a_mc_wrap: assert property (p_mc_wrap) else $error("cycle not twelve periods");
endmodule
`default_nettype wire

//--- expanded_bus_memory_interface_tb.sv
// self-checking bench for the expanded memory bus block
`default_nettype none
module expanded_bus_memory_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ext_n = 1'b1;
    logic hreadyout, hresp, ale, prog_n, rd_n, wr_n, mem_oe;
    logic [31:0] hrdata, q;
    logic [7:0] lo_out, lo_oe, lo_pu, hi_out, hi_oe, hi_pu, pins, hi_pins, mem_d, wdat;
    logic [15:0] waddr, addr, prev_addr;
    logic p_ale = 1'b0, p_prog = 1'b1, p_rd = 1'b1, chk_fetch = 1'b0, have_prev = 1'b0;
    logic claimed;
    int bad_count = 0, n_tests = 0, cyc = 0;
    int n_ale = 0, n_prog = 0, n_rd = 0, n_rd_lo = 0, n_mv = 0, b_ale, b_prog, b_rd;
    logic [7:0] last_code = 8'h00;
    // wire level: the block wins while enabled, else whatever the memory leaves
    always_comb for (int i = 0; i < 8; i++) pins[i] = lo_oe[i] ? lo_out[i] : mem_d[i];
    assign hi_pins = hi_out | ~hi_oe;
    emb_bus uut (.clock(clock), .rst(rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .external_access_pin_n(ext_n),
        .low_addr_data_port_in(pins), .low_addr_data_port_out(lo_out),
        .low_addr_data_port_oe(lo_oe), .low_addr_data_port_pu(lo_pu),
        .high_addr_port_out(hi_out), .high_addr_port_oe(hi_oe), .high_addr_port_pu(hi_pu),
        .ale(ale), .program_read_strobe_n(prog_n), .read_strobe_pin_n(rd_n),
        .write_strobe_pin_n(wr_n), .ports_claimed(claimed));
    emb_mem_model mem (.clock(clock), .ale(ale), .low_pins(pins), .high_pins(hi_pins),
        .program_read_strobe_n(prog_n), .read_strobe_pin_n(rd_n),
        .write_strobe_pin_n(wr_n), .drive(mem_d), .drive_oe(mem_oe), .wr_addr(waddr),
        .wr_data(wdat));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    // one single word transfer; called just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_idle();
        int i;
        i = 0;
        do begin
            xfer(1'b0, emb_pkg::OFS_STAT, 32'h0);
            i++;
        end while (q[16] !== 1'b0 && i < 40);
        chk({31'h0, q[16]}, 32'h0);
    endtask
    // pin activity counters, sampled mid-period where outputs are settled
    always @(negedge clock) begin
        p_ale <= ale;
        p_prog <= prog_n;
        p_rd <= rd_n;
        if (ale && !p_ale) n_ale++;
        if (!prog_n && p_prog) n_prog++;
        if (!rd_n && p_rd) n_rd++;
        if (!rd_n) n_rd_lo++;
        if ((!rd_n || !wr_n) && (ale || !prog_n)) n_mv++;
        if (!ale && p_ale && chk_fetch) begin
            addr = {hi_out, pins};
            if (have_prev) chk({16'h0, addr}, {16'h0, prev_addr + 16'h1});
            chk({lo_oe, lo_pu, hi_pu}, {8'hff, lo_out, hi_out});
            prev_addr = addr;
            have_prev = 1'b1;
            last_code = addr[7:0] ^ addr[15:8] ^ 8'h3c;
        end
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        xfer(1'b0, emb_pkg::OFS_CFG, 32'h0);
        chk(q, 32'h80);
        xfer(1'b0, emb_pkg::OFS_PORT, 32'h0);
        chk(q, 32'hffff);
        xfer(1'b0, 8'h18, 32'h0);
        chk(q, 32'h0);
        // external code fetch
        xfer(1'b1, emb_pkg::OFS_PORT, 32'h3412);
        xfer(1'b1, emb_pkg::OFS_PC, 32'ha510);
        ext_n <= 1'b0;
        repeat (5) @(posedge clock);
        xfer(1'b1, emb_pkg::OFS_CFG, 32'h580);
        repeat (12) @(posedge clock);
        chk_fetch <= 1'b1;
        b_ale = n_ale;
        b_prog = n_prog;
        repeat (24) @(posedge clock);
        chk(n_ale - b_ale, 4);
        chk(n_prog - b_prog, 4);
        chk({31'h0, claimed}, 32'h1);
        xfer(1'b0, emb_pkg::OFS_STAT, 32'h0);
        chk({31'h0, q[17]}, 32'h1);
        xfer(1'b0, emb_pkg::OFS_PORT, 32'h0);
        chk(q, 32'h34ff);
        xfer(1'b1, emb_pkg::OFS_CFG, 32'h180);
        repeat (24) @(posedge clock);
        chk_fetch <= 1'b0;
        xfer(1'b0, emb_pkg::OFS_STAT, 32'h0);
        chk({24'h0, q[7:0]}, {24'h0, last_code});
        // internal code fetch
        ext_n <= 1'b1;
        xfer(1'b1, emb_pkg::OFS_PC, 32'h0010);
        repeat (5) @(posedge clock);
        xfer(1'b1, emb_pkg::OFS_CFG, 32'h580);
        repeat (12) @(posedge clock);
        b_ale = n_ale;
        b_prog = n_prog;
        repeat (24) @(posedge clock);
        chk(n_ale - b_ale, 4);
        chk(n_prog - b_prog, 0);
        // pointer data read, then register-indirect write
        ext_n <= 1'b0;
        xfer(1'b1, emb_pkg::OFS_PORT, 32'h9e12);
        xfer(1'b1, emb_pkg::OFS_DATA_POINTER_REG, 32'h9abc);
        repeat (5) @(posedge clock);
        b_rd = n_rd;
        b_ale = n_rd_lo;
        b_prog = n_mv;
        xfer(1'b1, emb_pkg::OFS_XCMD, 32'h20000);
        wait_idle();
        chk({24'h0, q[15:8]}, {24'h0, 8'hbc ^ 8'h9a ^ 8'h3c});
        chk(n_rd - b_rd, 1);
        chk(n_rd_lo - b_ale, 4);
        chk(n_mv - b_prog, 0);
        xfer(1'b0, emb_pkg::OFS_PORT, 32'h0);
        chk(q, 32'h9eff);
        xfer(1'b1, emb_pkg::OFS_XCMD, 32'h1c35a);
        wait_idle();
        chk({16'h0, waddr}, 32'h9ec3);
        chk({24'h0, wdat}, 32'h5a);
        chk(n_mv - b_prog, 0);
        xfer(1'b1, emb_pkg::OFS_CFG, 32'h180);
        repeat (24) @(posedge clock);
        chk({24'h0, hi_out}, 32'h9e);
        give_verdict();
    end
endmodule
`default_nettype wire
